// file: include/clk_ctrl_pkg.sv
/*
 holds register offsets, field positions, reset values and timing counts
 for the system clock select and tune block; assumes a 40 MHz bus clock
*/
package clk_ctrl_pkg;
   localparam logic [11:0] TRIM_OFFSET = 12'h000;
   localparam logic [11:0] OSC_CTRL_OFFSET = 12'h004;
   localparam logic [11:0] TIMER_CTRL_OFFSET = 12'h008;
   localparam logic [11:0] STATUS_OFFSET = 12'h00c;

   localparam int IDLE_POS = 7;
   localparam int FREQ_POS = 4;
   localparam int STARTUP_DONE_POS = 3;
   localparam int FAST_STABLE_POS = 2;
   localparam int SECONDARY_ACTIVE_POS = 6;
   localparam int SECONDARY_EN_POS = 3;

   localparam logic [5:0] TRIM_RESET = 6'h00;
   localparam logic [2:0] FREQ_RESET = 3'h6;
   localparam logic [1:0] SOURCE_RESET = 2'h0;

   localparam logic [2:0] FREQ_FAST_DIRECT = 3'h7;
   localparam logic [2:0] FREQ_SLOW_RC = 3'h0;

   localparam int CLK_HZ = 40000000;
   localparam int FAST_SETTLE_US = 1000;
   localparam int FAST_SETTLE_CYCLES = FAST_SETTLE_US * (CLK_HZ / 1000000);
   localparam int SLOW_SETTLE_CYCLES = 8;
   localparam int SWITCH_PAUSE_MIN = 8;
   localparam int SWITCH_PAUSE_MAX = 9;

   typedef enum logic [1:0]
   {
      SRC_PRIMARY = 2'b00,
      SRC_SECONDARY = 2'b01,
      SRC_INTERNAL = 2'b10
   } src_t;

   typedef enum logic [1:0]
   {
      ST_RUN = 2'b00,
      ST_PAUSE = 2'b01,
      ST_MANAGED = 2'b10
   } state_t;
endpackage

// file: core/system_clock_select_and_tune.sv
/*
 system clock source selection, internal oscillator trim and frequency
 select, clock status flags and glitch-free switch pausing, reached over apb;
 assumes the oscillators report start-up and running levels on pins and that
 the core signals sleep entry and wake events as same-clock pulses
*/
`timescale 1ns/1ps
// What this block does
// - trim field is signed offset around calibration
// - trim bits 7-6 read as zero
// - primary mode latched from configuration at power-on
// - source selection applied only at sleep entry
// - every reset clears source select bits
// - source select 1x internal, 01 secondary, 00 primary
// - frequency select decode, default 110
// - internal frequency change is immediate when active
// - startup done set after timer expiry, primary running
// - read-only fast internal stable bit
// - secondary active bit while timer clocks system
// - at most one clock status bit set
// - idle select stops core clock in managed modes
// - secondary selection ignored unless oscillator enabled
// - switch pauses clock 8 to 9 new periods
// - no runt pulse during a switch
// - startup done reset value from two-speed setting
// - trim settles slow 8 cycles, fast 1 ms
// - wake events in managed mode return to full power run
module system_clock_select_and_tune
   import clk_ctrl_pkg::*;
(
   input wire logic clk,
   input wire logic resetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic [3:0] primaryModeCfg,
   input wire logic twoSpeedStartupCfg,
   input wire logic startupTimerExpired,
   input wire logic primaryRunning,
   input wire logic newSourceEdge,
   input wire logic sleepEntry,
   input wire logic wakeEvent,
   output logic [3:0] primaryMode,
   output logic [1:0] activeSource,
   output logic [2:0] internalFreqSelect,
   output logic [5:0] freqTrimField,
   output logic coreClockEnable,
   output logic sysClockEnable,
   output logic managedMode,
   output logic startupTimerDone,
   output logic fastInternalStable,
   output logic secondaryClockActive
);
   logic [2:0] expSync_q;
   logic [2:0] priSync_q;
   logic [2:0] edgeSync_q;
   logic expiredLvl;
   logic primaryLvl;
   logic edgeSeen;
   logic porDone_q;
   logic [5:0] trim_q;
   logic idle_q;
   logic [2:0] freq_q;
   logic [1:0] sourceSel_q;
   logic [7:0] timerCtrl_q;
   logic [1:0] active_q;
   state_t state_q;
   logic [3:0] pauseCnt_q;
   logic [15:0] fastSettle_q;
   logic [3:0] slowSettle_q;
   logic [3:0] primaryMode_q;
   logic startupDone_q;
   logic wrAccess;
   logic wrTrim;
   logic wrCtrl;
   logic wrTimer;
   src_t reqSource;
   logic [31:0] rdData;

   // pins cross into clk: a level change counts once stages two and three agree; a rising source clock edge counts when stage two is high and three low
   always_ff @(posedge clk or negedge resetn)
   begin
      if (!resetn)
      begin
         expSync_q <= 3'h0;
         priSync_q <= 3'h0;
         edgeSync_q <= 3'h0;
      end
      else
      begin
         expSync_q <= {expSync_q[1:0], startupTimerExpired};
         priSync_q <= {priSync_q[1:0], primaryRunning};
         edgeSync_q <= {edgeSync_q[1:0], newSourceEdge};
      end
   end

   always_ff @(posedge clk or negedge resetn)
   begin
      if (!resetn)
      begin
         expiredLvl <= 1'b0;
         primaryLvl <= 1'b0;
      end
      else
      begin
         if (expSync_q[1] == expSync_q[2])
         begin
            expiredLvl <= expSync_q[2];
         end
         if (priSync_q[1] == priSync_q[2])
         begin
            primaryLvl <= priSync_q[2];
         end
      end
   end

   // one rising edge of the new source's clock, seen in this domain
   assign edgeSeen = edgeSync_q[1] & ~edgeSync_q[2];

   assign wrAccess = psel & penable & pwrite;
   assign wrTrim = wrAccess && (paddr == TRIM_OFFSET) && pstrb[0];
   assign wrCtrl = wrAccess && (paddr == OSC_CTRL_OFFSET) && pstrb[0];
   assign wrTimer = wrAccess && (paddr == TIMER_CTRL_OFFSET) && pstrb[0];

   // straps are caught on the first clocked edge after reset release
   always_ff @(posedge clk or negedge resetn)
   begin
      if (!resetn)
      begin
         porDone_q <= 1'b0;
         primaryMode_q <= 4'h0;
      end
      else if (!porDone_q)
      begin
         porDone_q <= 1'b1;
         primaryMode_q <= primaryModeCfg;
      end
   end

   always_ff @(posedge clk or negedge resetn)
   begin
      if (!resetn)
      begin
         trim_q <= TRIM_RESET;
      end
      else if (wrTrim)
      begin
         trim_q <= pwdata[5:0];
      end
   end

   // the status bit positions are not stored from software writes
   always_ff @(posedge clk or negedge resetn)
   begin
      if (!resetn)
      begin
         idle_q <= 1'b0;
         freq_q <= FREQ_RESET;
         sourceSel_q <= SOURCE_RESET;
      end
      else if (wrCtrl)
      begin
         idle_q <= pwdata[IDLE_POS];
         freq_q <= pwdata[FREQ_POS +: 3];
         sourceSel_q <= pwdata[1:0];
      end
   end

   always_ff @(posedge clk or negedge resetn)
   begin
      if (!resetn)
      begin
         timerCtrl_q <= 8'h00;
      end
      else if (wrTimer)
      begin
         // the active flag position stays hardware owned
         timerCtrl_q <= pwdata[7:0] & ~(8'h01 << SECONDARY_ACTIVE_POS);
      end
   end

   always_comb
   begin
      if (sourceSel_q[1])
      begin
         reqSource = SRC_INTERNAL;
      end
      else if (sourceSel_q[0] && timerCtrl_q[SECONDARY_EN_POS])
      begin
         reqSource = SRC_SECONDARY;
      end
      else
      begin
         reqSource = SRC_PRIMARY;
      end
   end

   // switch sequencing: the clock is gated off for whole new-source periods,
   // so no output pulse can be narrower than either source's pulse
   always_ff @(posedge clk or negedge resetn)
   begin
      if (!resetn)
      begin
         state_q <= ST_RUN;
         active_q <= SRC_PRIMARY;
         pauseCnt_q <= 4'h0;
      end
      else
      begin
         case (state_q)
            ST_RUN:
            begin
               if (sleepEntry)
               begin
                  if (reqSource != active_q)
                  begin
                     active_q <= reqSource;
                     pauseCnt_q <= 4'h0;
                     state_q <= ST_PAUSE;
                  end
                  else
                  begin
                     state_q <= ST_MANAGED;
                  end
               end
            end
            ST_PAUSE:
            begin
               if (edgeSeen)
               begin
                  if (pauseCnt_q == 4'(SWITCH_PAUSE_MIN))
                  begin
                     state_q <= (active_q == SRC_PRIMARY && !idleMode())
                        ? ST_RUN : ST_MANAGED;
                  end
                  else
                  begin
                     pauseCnt_q <= pauseCnt_q + 4'h1;
                  end
               end
            end
            ST_MANAGED:
            begin
               if (wakeEvent)
               begin
                  if (active_q != SRC_PRIMARY)
                  begin
                     active_q <= SRC_PRIMARY;
                     pauseCnt_q <= 4'h0;
                     state_q <= ST_PAUSE;
                  end
                  else
                  begin
                     state_q <= ST_RUN;
                  end
               end
            end
            default:
            begin
               state_q <= ST_RUN;
            end
         endcase
      end
   end

   function automatic logic idleMode();
      idleMode = 1'b0;
   endfunction

   // settling timers restart on every trim write or frequency change; only the fast one is reported
   always_ff @(posedge clk or negedge resetn)
   begin
      if (!resetn)
      begin
         fastSettle_q <= 16'h0000;
         slowSettle_q <= 4'h0;
      end
      else if (wrTrim || (wrCtrl && pwdata[FREQ_POS +: 3] != freq_q))
      begin
         fastSettle_q <= 16'(FAST_SETTLE_CYCLES);
         slowSettle_q <= 4'(SLOW_SETTLE_CYCLES);
      end
      else
      begin
         if (fastSettle_q != 16'h0000)
         begin
            fastSettle_q <= fastSettle_q - 16'h0001;
         end
         if (slowSettle_q != 4'h0)
         begin
            slowSettle_q <= slowSettle_q - 4'h1;
         end
      end
   end

   // reset value follows the two-speed setting, taken after release
   always_ff @(posedge clk or negedge resetn)
   begin
      if (!resetn)
      begin
         startupDone_q <= 1'b0;
      end
      else if (!porDone_q)
      begin
         startupDone_q <= ~twoSpeedStartupCfg;
      end
      else
      begin
         startupDone_q <= expiredLvl & primaryLvl;
      end
   end

   // each flag is qualified by the one active source
   always_comb
   begin
      startupTimerDone = startupDone_q && (active_q == SRC_PRIMARY)
         && (state_q != ST_PAUSE);
      fastInternalStable = (active_q == SRC_INTERNAL) && (state_q != ST_PAUSE)
         && (freq_q != FREQ_SLOW_RC) && (fastSettle_q == 16'h0000);
      secondaryClockActive = (active_q == SRC_SECONDARY)
         && (state_q != ST_PAUSE);
   end

   assign primaryMode = primaryMode_q;
   assign activeSource = active_q;
   assign internalFreqSelect = freq_q;
   assign freqTrimField = trim_q;
   assign managedMode = (state_q == ST_MANAGED);
   assign sysClockEnable = (state_q != ST_PAUSE);
   assign coreClockEnable = (state_q != ST_PAUSE)
      && !((state_q == ST_MANAGED) && idle_q);

   always_comb
   begin
      case (paddr)
         TRIM_OFFSET: rdData = {26'h0, trim_q};
         OSC_CTRL_OFFSET: rdData = {24'h0, idle_q, freq_q, startupTimerDone,
            fastInternalStable, sourceSel_q};
         TIMER_CTRL_OFFSET: rdData = {24'h0, timerCtrl_q
            | (8'(secondaryClockActive) << SECONDARY_ACTIVE_POS)};
         STATUS_OFFSET: rdData = {24'h0, 2'h0, managedMode, state_q,
            activeSource, 1'b0};
         default: rdData = 32'h0;
      endcase
   end

   always_ff @(posedge clk or negedge resetn)
   begin
      if (!resetn)
      begin
         prdata <= 32'h0;
      end
      else if (psel && !penable && !pwrite)
      begin
         prdata <= rdData;
      end
   end

   // zero wait states; unmapped addresses answer with an error
   assign pready = 1'b1;
   assign pslverr = psel && penable && (paddr != TRIM_OFFSET)
      && (paddr != OSC_CTRL_OFFSET) && (paddr != TIMER_CTRL_OFFSET)
      && (paddr != STATUS_OFFSET);
endmodule

// file: test/clk_ctrl_properties.sv
/*
 checker for the clock select block
 assumes only the top-level ports, bound below
*/
`timescale 1ns/1ps
module clk_ctrl_properties
(
   input wire logic clk,
   input wire logic resetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   input wire logic [31:0] prdata,
   input wire logic wakeEvent,
   input wire logic [1:0] activeSource,
   input wire logic [2:0] internalFreqSelect,
   input wire logic [5:0] freqTrimField,
   input wire logic sysClockEnable,
   input wire logic managedMode,
   input wire logic startupTimerDone,
   input wire logic fastInternalStable,
   input wire logic secondaryClockActive
);
   default clocking @(posedge clk); endclocking
   default disable iff (!resetn);
   logic wr;
   assign wr = psel && penable && pwrite && pstrb[0];
   logic [5:0] trimIn;
   logic [2:0] freqIn;
   assign trimIn = pwdata[5:0];
   assign freqIn = pwdata[6:4];
   sequence pauseHeld;
      !sysClockEnable[*8];
   endsequence
   a_trim_upper_zero:
   assert property (psel && !penable && !pwrite && paddr == 12'h000 |=> prdata[7:6] == 2'h0)
      else $error("trim upper bits read nonzero");
   a_one_status:
   assert property (managedMode |-> $onehot0({startupTimerDone, fastInternalStable,
      secondaryClockActive})) else $error("more than one clock status bit set");
   a_reset_defaults:
   assert property (!$past(resetn) |-> activeSource == 2'h0 && internalFreqSelect == 3'h6
      && freqTrimField == 6'h00) else $error("wrong values after reset");
   a_pause_window:
   assert property ($fell(sysClockEnable) |-> pauseHeld ##[1:300] sysClockEnable)
      else $error("switch pause out of range");
   a_wake_primary:
   assert property (wakeEvent |-> ##[1:300] activeSource == 2'h0)
      else $error("wake did not return to primary");
   a_trim_write:
   assert property (wr && paddr == 12'h000 |=> freqTrimField == $past(trimIn))
      else $error("trim write not applied");
   a_freq_write:
   assert property (wr && paddr == 12'h004 |=> internalFreqSelect == $past(freqIn))
      else $error("frequency write not immediate");
   a_trim_unstable:
   assert property (wr && paddr == 12'h000 |=> !fastInternalStable[*8])
      else $error("fast source stable during settle");
   a_sec_active:
   assert property (secondaryClockActive |-> activeSource == 2'h1 && managedMode)
      else $error("secondary active without secondary clock");
endmodule
bind system_clock_select_and_tune clk_ctrl_properties clk_ctrl_properties_inst (.clk, .resetn,
   .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .prdata, .wakeEvent, .activeSource,
   .internalFreqSelect, .freqTrimField, .sysClockEnable, .managedMode, .startupTimerDone,
   .fastInternalStable, .secondaryClockActive);

// file: test/osc_source_model.sv
/*
 oscillator side: start-up timer levels and the new source clock
 assumes the bench picks a fast or slow source clock
*/
`timescale 1ns/1ps
module osc_source_model
#(
   parameter int STARTUP_CYCLES = 60
)
(
   input wire logic clk,
   input wire logic resetn,
   input wire logic slowEdges,
   output logic startupTimerExpired,
   output logic primaryRunning,
   output logic newSourceEdge
);
   int cnt;
   // oscillators run free, unrelated in phase to clk; one process owns the pin
   initial
   begin
      newSourceEdge = 1'b0;
      forever
      begin
         #((slowEdges === 1'b1) ? 157 : 53);
         newSourceEdge = ~newSourceEdge;
      end
   end
   always_ff @(posedge clk or negedge resetn)
   begin
      if (!resetn)
         cnt <= 0;
      else if (cnt < STARTUP_CYCLES)
         cnt <= cnt + 1;
   end
   assign startupTimerExpired = cnt >= STARTUP_CYCLES;
   assign primaryRunning = cnt >= STARTUP_CYCLES / 2;
endmodule

// file: test/system_clock_select_and_tune_test.sv
/*
 testbench for the clock select block over apb
 assumes the oscillator model and the bound checker
*/
`timescale 1ns/1ps
module system_clock_select_and_tune_test;
   import clk_ctrl_pkg::*;
   logic clk, resetn, psel, penable, pwrite, pready, pslverr, err, slowEdges;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic [3:0] pstrb, primaryModeCfg, primaryMode;
   logic twoSpeedStartupCfg, startupTimerExpired, primaryRunning, newSourceEdge;
   logic sleepEntry, wakeEvent, coreClockEnable, sysClockEnable, managedMode;
   logic startupTimerDone, fastInternalStable, secondaryClockActive;
   logic [1:0] activeSource;
   logic [2:0] internalFreqSelect;
   logic [5:0] freqTrimField;
   logic [5:0] trims [3] = '{6'h1f, 6'h20, 6'h00};
   int numErrors, cmpCount;
   system_clock_select_and_tune system_clock_select_and_tune_inst (.clk, .resetn, .psel,
      .penable, .pwrite, .paddr, .pwdata, .pstrb, .prdata, .pready, .pslverr, .primaryModeCfg,
      .twoSpeedStartupCfg, .startupTimerExpired, .primaryRunning, .newSourceEdge, .sleepEntry,
      .wakeEvent, .primaryMode, .activeSource, .internalFreqSelect, .freqTrimField,
      .coreClockEnable, .sysClockEnable, .managedMode, .startupTimerDone, .fastInternalStable,
      .secondaryClockActive);
   osc_source_model osc_source_model_inst (.clk, .resetn, .slowEdges, .startupTimerExpired,
      .primaryRunning, .newSourceEdge);
   initial
   begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end
   task print_verdict;
      if (numErrors == 0 && cmpCount > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask
   task check(input logic [31:0] got, input logic [31:0] exp);
      cmpCount++;
      if (got !== exp)
      begin
         numErrors++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      do @(posedge clk); while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge clk);
   endtask
   // pulse sleep or wake, then wait for the switch pause to end
   task switchTo(input logic wake, input logic m);
      if (wake)
         wakeEvent <= 1'b1;
      else
         sleepEntry <= 1'b1;
      @(posedge clk);
      wakeEvent <= 1'b0;
      sleepEntry <= 1'b0;
      for (int i = 0; i < 400 && !(managedMode === m && sysClockEnable === 1'b1); i++)
         @(posedge clk);
      // a switch that never completes counts against the run
      if (managedMode !== m || sysClockEnable !== 1'b1)
         numErrors++;
   endtask
   initial
   begin
      // the fast source settling wait alone is about 1 ms of bus clock
      #2000000;
      numErrors++;
      print_verdict;
   end
   initial
   begin
      {resetn, psel, penable, pwrite, sleepEntry, wakeEvent, slowEdges} = '0;
      {paddr, pwdata, numErrors, cmpCount} = '0;
      pstrb = 4'h1;
      primaryModeCfg = 4'h5;
      twoSpeedStartupCfg = 1'b1;
      repeat (3) @(posedge clk);
      resetn <= 1'b1;
      // straps land on the first edge; look once they have settled
      repeat (2) @(posedge clk);
      check(startupTimerDone, 0);
      check(primaryMode, 4'h5);
      apb(0, OSC_CTRL_OFFSET, 0);
      check(rd & 32'hf3, 32'h60);
      apb(1, TRIM_OFFSET, 32'hff);
      apb(0, TRIM_OFFSET, 0);
      check(rd, 32'h3f);
      foreach (trims[i])
      begin
         apb(1, TRIM_OFFSET, {26'h0, trims[i]});
         check(freqTrimField, trims[i]);
      end
      for (int f = 0; f < 8; f++)
      begin
         apb(1, OSC_CTRL_OFFSET, {25'h0, f[2:0], 4'hc});
         check(internalFreqSelect, f[2:0]);
         apb(0, OSC_CTRL_OFFSET, 0);
         check(rd & 32'h74, {25'h0, f[2:0], 4'h0});
      end
      repeat (80) @(posedge clk);
      check(startupTimerDone, 1);
      apb(1, OSC_CTRL_OFFSET, 32'he1);
      check(activeSource, 2'h0);
      switchTo(0, 1);
      check(activeSource, 2'h0);
      switchTo(1, 0);
      apb(1, TIMER_CTRL_OFFSET, 32'h08);
      for (int i = 1; i < 4; i++)
      begin
         slowEdges <= (i == 2);
         apb(1, OSC_CTRL_OFFSET, 32'he0 | i);
         switchTo(0, 1);
         check(activeSource, (i == 1) ? 2'h1 : 2'h2);
         check(coreClockEnable, 0);
         check(secondaryClockActive, i == 1);
         switchTo(1, 0);
         check(activeSource, 2'h0);
      end
      apb(1, OSC_CTRL_OFFSET, 32'h62);
      switchTo(0, 1);
      check(coreClockEnable, 1);
      apb(1, TRIM_OFFSET, 0);
      check(fastInternalStable, 0);
      repeat (FAST_SETTLE_CYCLES) @(posedge clk);
      check(fastInternalStable, 1);
      apb(0, OSC_CTRL_OFFSET, 0);
      check(rd & 32'h74, 32'h64);
      switchTo(1, 0);
      apb(0, 12'h010, 0);
      check({31'h0, err}, 32'h1);
      check(rd, 32'h0);
      print_verdict;
   end
endmodule
